// ===== batch_seq_pkg.sv
// Purpose: Shared constants, register map and field layouts of the batch setpoint sequencer.
// Assumes: One system clock at 125 MHz and a register bus with 32-bit data.
// Notes:   Step and monitor entries share one 32-bit layout.
package batch_seq_pkg;

    // =========================================================
    // Timing
    // =========================================================
    localparam int CLOCK_PERIOD_NS = 8;
    localparam int TICK_PERIOD_NS  = 100_000_000;
    localparam int TICK_CYCLES_DEF = (TICK_PERIOD_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;

    // =========================================================
    // Sizes
    // =========================================================
    localparam int N_STEPS = 8;
    localparam int IDX_W   = 3;
    localparam int N_OUT   = 8;
    localparam int VAL_W   = 16;

    // =========================================================
    // Register map
    // =========================================================
    localparam logic [11:0] CTRL_OFS      = 12'h000;
    localparam logic [11:0] STATUS_OFS    = 12'h004;
    localparam logic [11:0] LIMITS_OFS    = 12'h008;
    localparam logic [11:0] STEP_BASE_OFS = 12'h040;
    localparam logic [11:0] MON_BASE_OFS  = 12'h080;
    localparam logic [31:0] ENTRY_MASK    = 32'hffff_777f;

    localparam int CTRL_MODE_LSB   = 0;
    localparam int CTRL_LAST_LSB   = 4;
    localparam int CTRL_START_BIT  = 8;
    localparam int STAT_STEP_LSB   = 0;
    localparam int STAT_ACTIVE_BIT = 4;
    localparam int STAT_JOG_BIT    = 5;
    localparam int STAT_PEND_BIT   = 6;
    localparam int STAT_RUNS_LSB   = 8;
    localparam int STAT_DOUT_LSB   = 24;
    localparam int LIM_UNDER_LSB   = 0;
    localparam int LIM_OVER_LSB    = 16;

    localparam logic [VAL_W-1:0] ONE_RUN = 16'h0001;

    // Synchroniser lanes of the front-end status pins and the batch start input.
    localparam int SYN_STANDSTILL = 0;
    localparam int SYN_ZERO       = 1;
    localparam int SYN_RANGE      = 2;
    localparam int SYN_START      = 3;

    // =========================================================
    // Types
    // =========================================================
    typedef enum logic [1:0] {
        SEL_OFF    = 2'h0,
        SEL_AUTO   = 2'h1,
        SEL_MANUAL = 2'h2
    } batching_select_t;

    typedef enum logic [3:0] {
        ST_OFF                  = 4'h0,
        ST_WEIGHT               = 4'h1,
        ST_DELAY                = 4'h2,
        ST_STANDSTILL_WAIT_STEP = 4'h3,
        ST_COUNTER              = 4'h4,
        ST_REFILL               = 4'h5,
        ST_PAUSE                = 4'h6,
        ST_CLOCK_MATCH          = 4'h7,
        ST_DELTA                = 4'h8,
        ST_ALWAYS               = 4'h9,
        ST_NEVER                = 4'ha
    } step_kind_t;

    typedef enum logic [3:0] {
        MK_OFF                  = 4'h0,
        MK_ZERO_MONITOR         = 4'h1,
        MK_MOTION_MONITOR       = 4'h2,
        MK_RANGE_MONITOR        = 4'h3,
        MK_BATCH_ACTIVE_MONITOR = 4'h4,
        MK_WATCHDOG             = 4'h5,
        MK_CONCUR               = 4'h6,
        MK_CLOCK_MATCH          = 4'h7,
        MK_CHECKWEIGHER         = 4'h8
    } mon_kind_t;

    // Steps use sel_c as branch target; monitors use sel_b/sel_c as start/end
    // (checkweigher: out_sel over, sel_b under, sel_c accept).
    typedef struct packed {
        logic [VAL_W-1:0] value;
        logic             pad2;
        logic [IDX_W-1:0] sel_c;
        logic             pad1;
        logic [IDX_W-1:0] sel_b;
        logic             pad0;
        logic [IDX_W-1:0] out_sel;
        logic [3:0]       kind;
    } entry_t;

endpackage : batch_seq_pkg

// ===== batch_setpoint_sequencer.sv
// Purpose: Batch step sequencer and continuous setpoint monitors with an APB register file.
// Assumes: Weight and time of day come from logic on CLOCK_I; status pins are asynchronous.
// Notes:   All timing runs on a tenth-of-a-second tick derived from CLOCK_I.
//
// The register offsets and the APB interface to the registers were decided locally.
module batch_setpoint_sequencer
    import batch_seq_pkg::*;
#(
    parameter int TICK_CYCLES = TICK_CYCLES_DEF,
    parameter int N_MON       = 4
) (
    input  wire logic             CLOCK_I,
    input  wire logic             RESETN_I,
    input  wire logic             CE_I,
    input  wire logic             PSEL_I,
    input  wire logic             PENABLE_I,
    input  wire logic             PWRITE_I,
    input  wire logic [11:0]      PADDR_I,
    input  wire logic [31:0]      PWDATA_I,
    output logic      [31:0]      PRDATA_O,
    output logic                  PREADY_O,
    output logic                  PSLVERR_O,
    input  wire logic             STANDSTILL_I,
    input  wire logic             CENTRE_ZERO_I,
    input  wire logic             IN_RANGE_I,
    input  wire logic             BATCH_START_INPUT_I,
    input  wire logic [VAL_W-1:0] WEIGHT_I,
    input  wire logic [VAL_W-1:0] TIME_OF_DAY_I,
    output logic      [N_OUT-1:0] DOUT_O
);

    // =========================================================
    // State
    // =========================================================
    localparam int MON_IW  = (N_MON > 1) ? $clog2(N_MON) : 1;
    localparam int PRESC_W = $clog2(TICK_CYCLES) + 1;

    typedef enum logic [1:0] {SEQ_IDLE, SEQ_STEP, SEQ_REFILL} seq_t;

    typedef struct packed {
        logic [3:0]                    sync1;
        logic [3:0]                    sync2;
        logic [3:0]                    sync3;
        logic [3:0]                    filt;
        logic                          start_d;
        logic [PRESC_W-1:0]            presc;
        logic                          tick;
        logic [1:0]                    mode;
        logic [IDX_W-1:0]              last_step;
        logic                          start_pend;
        logic [VAL_W-1:0]              lim_under;
        logic [VAL_W-1:0]              lim_over;
        logic [N_STEPS-1:0][31:0]      steps;
        logic [N_MON-1:0][31:0]        mons;
        seq_t                          seq;
        logic [IDX_W-1:0]              cur;
        logic                          entered;
        logic [VAL_W-1:0]              runs_left;
        logic                          count_loaded;
        logic [VAL_W-1:0]              timer;
        logic [VAL_W-1:0]              ref_weight;
        logic [IDX_W-1:0]              prev_weight;
        logic                          have_prev;
        logic [N_MON-1:0][VAL_W-1:0]   mon_timer;
        logic [N_MON-1:0]              mon_run;
        logic [N_MON-1:0]              mon_flag;
        logic [N_OUT-1:0]              dout;
        logic [31:0]                   rdata;
        logic                          err;
        logic                          rd_ok;
    } state_t;

    state_t s;
    state_t next_s;

    // =========================================================
    // Bus handshake
    // =========================================================
    // Read data is captured in the setup cycle, so the access completes
    // at once unless the clock enable is low.
    assign PREADY_O  = CE_I & s.rd_ok & PSEL_I & PENABLE_I;
    assign PRDATA_O  = s.rdata;
    assign PSLVERR_O = s.err & PREADY_O;
    assign DOUT_O    = s.dout;

    // =========================================================
    // Next state
    // =========================================================
    always_comb begin
        entry_t           st;
        entry_t           pe;
        entry_t           me;
        logic             acc;
        logic             wr;
        logic             bad;
        logic [31:0]      rdv;
        logic             sev;
        logic             consume;
        logic             sat;
        logic             branch;
        logic             wmet;
        logic             hs;
        logic             he;
        logic             over;
        logic             under;
        logic [VAL_W-1:0] diff;
        logic [N_OUT-1:0] drv;
        logic [2:0]       widx;
        st      = entry_t'(s.steps[s.cur]);
        pe      = entry_t'(s.steps[s.prev_weight]);
        wmet    = !s.have_prev || (WEIGHT_I >= pe.value);
        me      = '0;
        acc     = PSEL_I & PENABLE_I & s.rd_ok;
        wr      = acc & PWRITE_I;
        bad     = 1'b0;
        rdv     = '0;
        sev     = 1'b0;
        consume = 1'b0;
        sat     = 1'b0;
        branch  = 1'b0;
        hs      = 1'b0;
        he      = 1'b0;
        over    = 1'b0;
        under   = 1'b0;
        drv     = '0;
        widx    = PADDR_I[4:2];
        diff    = (WEIGHT_I >= s.ref_weight) ? WEIGHT_I - s.ref_weight : s.ref_weight - WEIGHT_I;
        next_s  = s;

        // Status pins: a change counts once the second and third stages agree.
        next_s.sync1   = {BATCH_START_INPUT_I, IN_RANGE_I, CENTRE_ZERO_I, STANDSTILL_I};
        next_s.sync2   = s.sync1;
        next_s.sync3   = s.sync2;
        next_s.filt    = (s.sync2 & s.sync3) | (s.filt & (s.sync2 | s.sync3));
        next_s.start_d = s.filt[SYN_START];
        sev            = s.filt[SYN_START] & ~s.start_d;

        // Tenth-of-a-second tick.
        next_s.tick = 1'b0;
        if (s.presc == PRESC_W'(TICK_CYCLES - 1)) begin
            next_s.presc = '0;
            next_s.tick  = 1'b1;
        end else begin
            next_s.presc = s.presc + 1'b1;
        end

        // ===== Register decode =====
        if (PADDR_I == CTRL_OFS) begin
            rdv[CTRL_MODE_LSB +: 2]     = s.mode;
            rdv[CTRL_LAST_LSB +: IDX_W] = s.last_step;
        end else if (PADDR_I == STATUS_OFS) begin
            rdv[STAT_STEP_LSB +: IDX_W] = s.cur;
            rdv[STAT_ACTIVE_BIT]        = (s.seq != SEQ_IDLE);
            rdv[STAT_JOG_BIT]           = (s.seq == SEQ_REFILL);
            rdv[STAT_PEND_BIT]          = s.start_pend;
            rdv[STAT_RUNS_LSB +: VAL_W] = s.runs_left;
            rdv[STAT_DOUT_LSB +: N_OUT] = s.dout;
        end else if (PADDR_I == LIMITS_OFS) begin
            rdv[LIM_UNDER_LSB +: VAL_W] = s.lim_under;
            rdv[LIM_OVER_LSB +: VAL_W]  = s.lim_over;
        end else if (PADDR_I[11:5] == STEP_BASE_OFS[11:5] && PADDR_I[1:0] == 2'h0) begin
            rdv = s.steps[widx];
        end else if (PADDR_I[11:5] == MON_BASE_OFS[11:5] && PADDR_I[1:0] == 2'h0
                     && int'(widx) < N_MON) begin
            rdv = s.mons[widx[MON_IW-1:0]];
        end else begin
            bad = 1'b1;
        end

        next_s.rd_ok = PSEL_I & ~acc;
        if (PSEL_I && !s.rd_ok) begin
            next_s.rdata = rdv;
            next_s.err   = bad;
        end

        if (wr && !bad) begin
            if (PADDR_I == CTRL_OFS) begin
                next_s.mode      = PWDATA_I[CTRL_MODE_LSB +: 2];
                next_s.last_step = PWDATA_I[CTRL_LAST_LSB +: IDX_W];
                sev              = sev | PWDATA_I[CTRL_START_BIT];
            end else if (PADDR_I == LIMITS_OFS) begin
                next_s.lim_under = PWDATA_I[LIM_UNDER_LSB +: VAL_W];
                next_s.lim_over  = PWDATA_I[LIM_OVER_LSB +: VAL_W];
            end else if (PADDR_I[11:5] == STEP_BASE_OFS[11:5]) begin
                next_s.steps[widx] = PWDATA_I & ENTRY_MASK;
            end else if (PADDR_I[11:5] == MON_BASE_OFS[11:5]) begin
                next_s.mons[widx[MON_IW-1:0]] = PWDATA_I & ENTRY_MASK;
            end
        end

        // ===== Batch sequence =====
        next_s.entered = 1'b0;
        unique case (s.seq)
            SEQ_IDLE: begin
                if (s.mode == SEL_AUTO || (s.mode == SEL_MANUAL && s.start_pend)) begin
                    consume             = 1'b1;
                    next_s.seq          = SEQ_STEP;
                    next_s.cur          = '0;
                    next_s.entered      = 1'b1;
                    next_s.runs_left    = ONE_RUN;
                    next_s.count_loaded = 1'b0;
                    next_s.have_prev    = 1'b0;
                    next_s.timer        = '0;
                    next_s.ref_weight   = WEIGHT_I;
                end
            end
            SEQ_STEP: begin
                if (s.tick) begin
                    next_s.timer = s.timer + 1'b1;
                end
                unique case (step_kind_t'(st.kind))
                    ST_OFF: sat = 1'b1;
                    ST_ALWAYS: sat = 1'b1;
                    ST_WEIGHT: begin
                        sat = (WEIGHT_I >= st.value);
                        if (sat) begin
                            next_s.prev_weight = s.cur;
                            next_s.have_prev   = 1'b1;
                        end
                    end
                    ST_DELAY: sat = (s.timer > st.value);
                    ST_STANDSTILL_WAIT_STEP: sat = s.filt[SYN_STANDSTILL];
                    ST_COUNTER: begin
                        sat = 1'b1;
                        // Loaded once per batch so that later repeats keep counting down.
                        if (!s.count_loaded) begin
                            next_s.runs_left    = st.value;
                            next_s.count_loaded = 1'b1;
                        end
                    end
                    ST_REFILL: begin
                        if (s.filt[SYN_STANDSTILL]) begin
                            if (wmet) begin
                                sat = 1'b1;
                            end else begin
                                next_s.seq   = SEQ_REFILL;
                                next_s.timer = '0;
                            end
                        end
                    end
                    ST_PAUSE: begin
                        sat     = s.start_pend;
                        consume = s.start_pend;
                    end
                    ST_CLOCK_MATCH: sat = (TIME_OF_DAY_I == st.value);
                    ST_DELTA: sat = (diff >= st.value);
                    ST_NEVER: branch = 1'b1;
                    default: sat = 1'b1;
                endcase
                if (sat || branch) begin
                    next_s.timer      = '0;
                    next_s.ref_weight = WEIGHT_I;
                    next_s.entered    = 1'b1;
                end
                if (branch) begin
                    next_s.cur = st.sel_c;
                end else if (sat) begin
                    if (s.cur != s.last_step) begin
                        next_s.cur = s.cur + 1'b1;
                    end else if (s.runs_left > ONE_RUN) begin
                        next_s.runs_left = s.runs_left - 1'b1;
                        next_s.cur       = '0;
                    end else begin
                        next_s.seq       = SEQ_IDLE;
                        next_s.runs_left = '0;
                        next_s.entered   = 1'b0;
                    end
                end
            end
            SEQ_REFILL: begin
                if (s.timer >= st.value) begin
                    next_s.seq   = SEQ_STEP;
                    next_s.timer = '0;
                end else if (s.tick) begin
                    next_s.timer = s.timer + 1'b1;
                end
            end
            default: next_s.seq = SEQ_IDLE;
        endcase

        // Selecting off aborts a running sequence at once.
        if (s.mode != SEL_AUTO && s.mode != SEL_MANUAL) begin
            next_s.seq     = SEQ_IDLE;
            next_s.entered = 1'b0;
        end

        // A start arriving while the pending one is taken is kept.
        next_s.start_pend = (s.start_pend & ~consume) | sev;

        // ===== Output drive =====
        if (s.seq == SEQ_STEP && step_kind_t'(st.kind) == ST_WEIGHT && WEIGHT_I < st.value) begin
            drv[st.out_sel] = 1'b1;
        end
        if (s.seq != SEQ_IDLE && step_kind_t'(st.kind) == ST_REFILL) begin
            drv[st.out_sel] = 1'b1;
        end
        if (s.seq == SEQ_REFILL) begin
            drv[pe.out_sel] = 1'b1;
        end

        for (int m = 0; m < N_MON; m++) begin
            me    = entry_t'(s.mons[m]);
            hs    = s.entered && (s.cur == me.sel_b);
            he    = s.entered && (s.cur == me.sel_c);
            over  = (WEIGHT_I > s.lim_over);
            under = (WEIGHT_I < s.lim_under);
            if (mon_kind_t'(me.kind) != MK_WATCHDOG && mon_kind_t'(me.kind) != MK_CONCUR) begin
                next_s.mon_run[m]  = 1'b0;
                next_s.mon_flag[m] = 1'b0;
            end
            unique case (mon_kind_t'(me.kind))
                MK_ZERO_MONITOR: drv[me.out_sel] |= s.filt[SYN_ZERO];
                MK_MOTION_MONITOR: drv[me.out_sel] |= ~s.filt[SYN_STANDSTILL];
                MK_RANGE_MONITOR: drv[me.out_sel] |= s.filt[SYN_RANGE];
                MK_BATCH_ACTIVE_MONITOR: drv[me.out_sel] |= (s.seq != SEQ_IDLE);
                MK_WATCHDOG: begin
                    if (hs) begin
                        next_s.mon_run[m]   = 1'b1;
                        next_s.mon_timer[m] = '0;
                        next_s.mon_flag[m]  = 1'b0;
                    end else if (s.mon_run[m]) begin
                        if (he) begin
                            next_s.mon_run[m] = 1'b0;
                        end else if (s.mon_timer[m] >= me.value) begin
                            next_s.mon_run[m]  = 1'b0;
                            next_s.mon_flag[m] = 1'b1;
                        end else if (s.tick) begin
                            next_s.mon_timer[m] = s.mon_timer[m] + 1'b1;
                        end
                    end
                    drv[me.out_sel] |= s.mon_flag[m];
                end
                MK_CONCUR: begin
                    if (hs) begin
                        next_s.mon_flag[m]  = 1'b1;
                        next_s.mon_timer[m] = '0;
                    end else if (s.mon_flag[m]) begin
                        if (me.value == '0) begin
                            if (he) begin
                                next_s.mon_flag[m] = 1'b0;
                            end
                        end else if (s.mon_timer[m] >= me.value) begin
                            next_s.mon_flag[m] = 1'b0;
                        end else if (s.tick) begin
                            next_s.mon_timer[m] = s.mon_timer[m] + 1'b1;
                        end
                    end
                    // Two concur monitors on one output simply OR together.
                    drv[me.out_sel] |= s.mon_flag[m];
                end
                MK_CLOCK_MATCH: drv[me.out_sel] |= (TIME_OF_DAY_I == me.value);
                MK_CHECKWEIGHER: begin
                    drv[me.out_sel] |= over;
                    drv[me.sel_b]   |= under;
                    drv[me.sel_c]   |= ~over & ~under;
                end
                default: ;
            endcase
        end
        next_s.dout = drv;
    end

    // =========================================================
    // Registers
    // =========================================================
    always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            s <= '0;
        end else if (CE_I) begin
            s <= next_s;
        end
    end

endmodule : batch_setpoint_sequencer

// ===== batch_seq_sva.sv
// Purpose: Port-level checks of the batch setpoint sequencer.
// Assumes: Monitor 0 settings are shadowed from bus writes.
// Notes:   Monitor outputs are checked only when asserting, as other sources may share a pin.
module batch_seq_sva
    import batch_seq_pkg::*;
(
    input wire logic             CLOCK_I,
    input wire logic             RESETN_I,
    input wire logic             CE_I,
    input wire logic             PSEL_I,
    input wire logic             PENABLE_I,
    input wire logic             PWRITE_I,
    input wire logic [11:0]      PADDR_I,
    input wire logic [31:0]      PWDATA_I,
    input wire logic [31:0]      PRDATA_O,
    input wire logic             PREADY_O,
    input wire logic             PSLVERR_O,
    input wire logic             STANDSTILL_I,
    input wire logic             CENTRE_ZERO_I,
    input wire logic             IN_RANGE_I,
    input wire logic [N_OUT-1:0] DOUT_O
);
    entry_t m;
    always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
        if (!RESETN_I) m <= '0;
        else if (PSEL_I && PENABLE_I && PREADY_O && PWRITE_I && PADDR_I == MON_BASE_OFS) m <= PWDATA_I;
    end
    default clocking @(posedge CLOCK_I); endclocking
    default disable iff (!RESETN_I);
    AST_READY_GATE: assert property (PREADY_O |-> PSEL_I && PENABLE_I && CE_I) else $error("ready out of access");
    AST_NO_WAIT: assert property ((PSEL_I && !PENABLE_I && CE_I) ##1 (PSEL_I && PENABLE_I && CE_I) |-> PREADY_O)
        else $error("access not answered at once");
    AST_ERR_GATE: assert property (PSLVERR_O |-> PREADY_O) else $error("error without ready");
    AST_ERR_DATA: assert property (PSLVERR_O |-> PRDATA_O == 32'h0) else $error("error with read data");
    AST_RESET_IDLE: assert property ($rose(RESETN_I) |-> DOUT_O == '0) else $error("outputs set after reset");
    AST_ZERO_MON: assert property ((m.kind == MK_ZERO_MONITOR && CENTRE_ZERO_I) [*6] |-> DOUT_O[m.out_sel])
        else $error("zero monitor output low");
    AST_MOTION_MON: assert property ((m.kind == MK_MOTION_MONITOR && !STANDSTILL_I) [*6] |-> DOUT_O[m.out_sel])
        else $error("motion monitor output low");
    AST_RANGE_MON: assert property ((m.kind == MK_RANGE_MONITOR && IN_RANGE_I) [*6] |-> DOUT_O[m.out_sel])
        else $error("range monitor output low");
endmodule : batch_seq_sva
bind batch_setpoint_sequencer batch_seq_sva batch_seq_sva_inst (.*);

// ===== batch_front_end_model.sv
// Purpose: Weighing front end that fills while its feed input is high.
// Assumes: One count of weight per clock while feeding.
// Notes:   Standstill drops while feeding, so motion is seen during every fill.
module batch_front_end_model
    import batch_seq_pkg::*;
(
    input  wire logic             clock_i,
    input  wire logic             resetn_i,
    input  wire logic             fill_i,
    output logic      [VAL_W-1:0] weight_o,
    output logic                  standstill_o,
    output logic                  zero_o,
    output logic                  range_o,
    output logic      [VAL_W-1:0] tod_o
);
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            weight_o     <= 16'h0;
            standstill_o <= 1'b1;
            tod_o        <= 16'h0;
        end else begin
            weight_o     <= weight_o + 16'(fill_i);
            standstill_o <= !fill_i;
            tod_o        <= tod_o + 16'h1;
        end
    end
    assign zero_o  = weight_o == 16'h0;
    assign range_o = weight_o < 16'hff00;
endmodule : batch_front_end_model

// ===== test_batch_setpoint_sequencer.sv
// Purpose: Self-checking bench of the batch setpoint sequencer.
// Assumes: Tick shortened to 10 clocks; the front end fills on output 0.
// Notes:   Bus replies are taken at the rising edge at which ready is seen high.
module test_batch_setpoint_sequencer;
    import batch_seq_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic clock = 1'b0, resetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, e;
    logic standstill, zero, range_ok;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0, prdata, q, d;
    logic [VAL_W-1:0] weight, clock_match, w, rnd = 16'hc98e;
    logic [N_OUT-1:0] dout;
    int err_count = 0, tests_run = 0, n;
    time t0;
    always #4 clock = ~clock;
    batch_setpoint_sequencer #(.TICK_CYCLES(10)) batch_setpoint_sequencer_inst (.CLOCK_I(clock), .RESETN_I(resetn),
        .CE_I(1'b1), .PSEL_I(psel), .PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata),
        .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr), .STANDSTILL_I(standstill), .CENTRE_ZERO_I(zero),
        .IN_RANGE_I(range_ok), .BATCH_START_INPUT_I(1'b0), .WEIGHT_I(weight), .TIME_OF_DAY_I(clock_match), .DOUT_O(dout));
    batch_front_end_model batch_front_end_model_inst (.clock_i(clock), .resetn_i(resetn), .fill_i(dout[0]),
        .weight_o(weight), .standstill_o(standstill), .zero_o(zero), .range_o(range_ok), .tod_o(clock_match));
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr
    function automatic logic [31:0] entry(input logic [3:0] k, input logic [2:0] o, input logic [15:0] v);
        return {v, 9'h0, o, k};
    endfunction : entry
    task cmp(input string nm, input logic [31:0] x, input logic [31:0] g);
        tests_run++;
        if (g !== x) begin
            err_count++;
            $display("wrong value %s: expected %h, seen %h", nm, x, g);
        end
    endtask : cmp
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        @(posedge clock);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, wr, a, wd};
        @(posedge clock);
        penable <= 1'b1;
        do @(posedge clock); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        {psel, penable} <= 2'b00;
    endtask : apb
    task wait_status(input logic [4:0] s);
        for (int i = 0; i < 400; i++) begin
            apb(1'b0, STATUS_OFS, 32'h0);
            if (q[4:0] === s) break;
        end
    endtask : wait_status
    task print_verdict;
        $display("checks %0d, mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : print_verdict
    initial begin
        repeat (10) @(posedge clock);
        resetn <= 1'b1;
    end
    initial begin
        #200000;
        err_count++;
        print_verdict;
    end
    initial begin
        repeat (11) @(posedge clock);
        apb(1'b0, CTRL_OFS, 32'h0);
        cmp("ctrl reset", 32'h0, q);
        apb(1'b0, 12'h0fc, 32'h0);
        cmp("unmapped error", 32'h1, 32'(e));
        cmp("unmapped data", 32'h0, q);
        for (int i = 0; i < 2; i++) begin
            apb(1'b1, MON_BASE_OFS, entry(i ? MK_RANGE_MONITOR : MK_ZERO_MONITOR, 3'h6, 16'h0));
            repeat (8) @(posedge clock);
            cmp("monitor output", 32'h1, 32'(dout[6]));
        end
        $display("registers and monitors done");
        rnd = lfsr(rnd);
        w = {10'h0, rnd[5:0]} + 16'h10;
        d = entry(ST_WEIGHT, 3'h0, w) | {16'h0, rnd & 16'hff00};
        apb(1'b1, MON_BASE_OFS, entry(MK_MOTION_MONITOR, 3'h7, 16'h0));
        apb(1'b1, MON_BASE_OFS + 12'h4, entry(MK_BATCH_ACTIVE_MONITOR, 3'h4, 16'h0));
        apb(1'b1, MON_BASE_OFS + 12'h8, entry(MK_CONCUR, 3'h5, 16'h0) | 32'h3100);
        apb(1'b1, STEP_BASE_OFS, entry(ST_COUNTER, 3'h2, 16'h1));
        apb(1'b1, STEP_BASE_OFS + 12'h4, d);
        apb(1'b0, STEP_BASE_OFS + 12'h4, 32'h0);
        cmp("step entry", d & ENTRY_MASK, q);
        apb(1'b1, STEP_BASE_OFS + 12'h8, entry(ST_REFILL, 3'h3, 16'h2));
        apb(1'b1, STEP_BASE_OFS + 12'hc, entry(ST_DELAY, 3'h1, 16'h3));
        apb(1'b1, CTRL_OFS, 32'h132);
        wait_status(5'h13);
        t0 = $time;
        cmp("filled weight", 32'h1, 32'(weight >= w && weight <= w + 16'h4));
        cmp("batch active", 32'h1, 32'(dout[4]));
        wait_status(5'h03);
        n = int'(($time - t0) / 8);
        cmp("delay span", 32'h1, 32'(n inside {[26:44]}));
        cmp("batch idle", 32'h0, 32'(dout[4]));
        cmp("concur released", 32'h0, 32'(dout[5]));
        $display("manual batch done");
        apb(1'b1, STEP_BASE_OFS, entry(ST_NEVER, 3'h2, 16'h0));
        apb(1'b1, CTRL_OFS, 32'h001);
        repeat (20) @(posedge clock);
        apb(1'b0, STATUS_OFS, 32'h0);
        cmp("held on branch", 32'h10, 32'(q[4:0]));
        apb(1'b1, CTRL_OFS, 32'h0);
        apb(1'b0, STATUS_OFS, 32'h0);
        cmp("aborted", 32'h0, 32'(q[4:0]));
        $display("branch and abort done");
        print_verdict;
    end
endmodule : test_batch_setpoint_sequencer
